// *** rtl/epi_pkg.sv ***
// Package: register map, field positions and codes of the external pin interrupt unit
package epi_pkg;

    // ------------------------------------------------------------------
    // Bus geometry
    // ------------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam int IDX_W = 10;

    // ------------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------------
    localparam logic [IDX_W-1:0] IDX_FLAGS = 10'h03C;
    localparam logic [IDX_W-1:0] IDX_ENABLE = 10'h03D;
    localparam logic [IDX_W-1:0] IDX_SENSE = 10'h069;
    localparam logic [IDX_W-1:0] IDX_MASK_LOW = 10'h06B;
    localparam logic [IDX_W-1:0] IDX_MASK_HIGH = 10'h06C;
    localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 10'h070;
    localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 10'h071;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] RST_FLAGS = 8'h00;
    localparam logic [7:0] RST_ENABLE = 8'h00;
    localparam logic [7:0] RST_SENSE = 8'h00;
    localparam logic [7:0] RST_MASK = 8'h00;

    // ------------------------------------------------------------------
    // Field positions shared by flags, enable, event status and event mask, and of the sense field
    // ------------------------------------------------------------------
    localparam int BIT_PIN = 0;
    localparam int BIT_GROUP_LOW = 6;
    localparam int BIT_GROUP_HIGH = 7;
    localparam logic [7:0] IMPL_BITS = 8'hC1;
    localparam int SENSE_LO = 0;
    localparam int SENSE_HI = 1;

    // ------------------------------------------------------------------
    // Sense modes of the single interrupt pin
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        EPI_SENSE_LOW = 2'b00,
        EPI_SENSE_ANY = 2'b01,
        EPI_SENSE_FALL = 2'b10,
        EPI_SENSE_RISE = 2'b11
    } epi_sense_e;

endpackage : epi_pkg

// *** rtl/epi_top.sv ***
// External pin interrupt unit: one sensed pin, sixteen change pins, APB registers
//
// Overview of operation
// - Sense field: low, any, falling, rising
// - Pin events detected regardless of pin direction
// - Pins 15..8 high group, 7..0 low
// - Pin watched when mask and group enabled
// - Mask bit k maps pin k, 8+k
// - Pin change raises wake request
// - Low level requests continuously while held
// - Edge modes need the running clock
// - Low level raises wake request too
// - Pin sampled before edge detection
// - Pin request needs enable and global enable
// - Group enables bits 7 and 6
// - Flags set on events, request when enabled
// - Flag cleared by handler or written one
// - Pin flag held zero in low mode
// - Three separate request vectors
//
// Register access over APB was decided locally.
`timescale 1ns/1ns

module epi_top #(
    parameter int PINS = 16,                               // Change pins
    parameter int GROUP_W = 8                              // Pins per group
) (
    input wire logic pclk,                                 // Bus clock, 50 MHz
    input wire logic presetn,                              // Async reset, low
    input wire logic psel,                                 // APB select
    input wire logic penable,                              // APB enable
    input wire logic pwrite,                               // APB direction
    input wire logic [epi_pkg::ADDR_W-1:0] paddr,          // APB byte address
    input wire logic [31:0] pwdata,                        // APB write data
    output logic [31:0] prdata,                            // APB read data
    output logic pready,                                   // APB ready
    output logic pslverr,                                  // APB error
    input wire logic sense_irq_pin,                        // Sensed pin level
    input wire logic [PINS-1:0] change_watch_pins,         // Change pin levels
    input wire logic global_irq_enable,                    // Processor I-flag
    input wire logic [2:0] handler_entry,                  // Vector taken pulses
    output logic req_sense_pin,                            // Pin vector request
    output logic req_group_low,                            // Low group request
    output logic req_group_high,                           // High group request
    output logic wake_request,                             // Wake from sleep
    output logic irq                                       // Event interrupt
);
    import epi_pkg::*;

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic [7:0] external_irq_flags;
    logic [7:0] external_irq_enable;
    logic [7:0] external_irq_sense_control;
    logic [7:0] pin_change_mask_low;
    logic [7:0] pin_change_mask_high;
    logic [7:0] irq_status;
    logic [7:0] irq_mask;
    logic pin_lat;
    logic pin_sync;
    logic pin_prev;
    logic [PINS-1:0] chg_lat;
    logic [PINS-1:0] chg_sync;
    logic [PINS-1:0] chg_prev;
    logic [PINS-1:0] pin_enabled;
    logic [PINS-1:0] pin_toggled;
    logic [1:0] sense_sel;
    logic sense_event;
    logic level_low_mode;
    logic group_low_set;
    logic group_high_set;
    logic [7:0] event_set;
    logic [IDX_W-1:0] acc_idx;
    logic acc_aligned;
    logic setup_phase;
    logic access_done;
    logic wr_done;
    logic rd_done;
    logic hit;
    logic [7:0] next_rdata;
    logic [7:0] flag_clear;

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    // Offsets are word indices, so the low two address bits must be zero
    assign acc_idx = paddr[ADDR_W-1:2];
    assign acc_aligned = (paddr[1:0] == 2'b00);
    assign setup_phase = psel & ~penable;
    assign access_done = psel & penable & pready;
    assign wr_done = access_done & pwrite & ~pslverr;
    assign rd_done = access_done & ~pwrite & ~pslverr;

    // Read mux and hit detection, evaluated in the setup cycle
    always_comb begin
        hit = acc_aligned;
        next_rdata = 8'h00;
        unique case (acc_idx)
            IDX_FLAGS: next_rdata = external_irq_flags;
            IDX_ENABLE: next_rdata = external_irq_enable;
            IDX_SENSE: next_rdata = external_irq_sense_control;
            IDX_MASK_LOW: next_rdata = pin_change_mask_low;
            IDX_MASK_HIGH: next_rdata = pin_change_mask_high;
            IDX_IRQ_STATUS: next_rdata = irq_status;
            IDX_IRQ_MASK: next_rdata = irq_mask;
            default: hit = 1'b0;
        endcase
    end

    // Answer registered in setup, so every access has one access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= setup_phase;
            if (setup_phase) begin
                pslverr <= ~hit;
                prdata <= (hit && !pwrite) ? {24'h00_0000, next_rdata} : 32'h0000_0000;
            end else begin
                pslverr <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Control registers written by software
    // ------------------------------------------------------------------
    // Sense field, enables, the two pin masks and the event mask
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            external_irq_sense_control <= RST_SENSE;
            external_irq_enable <= RST_ENABLE;
            pin_change_mask_low <= RST_MASK;
            pin_change_mask_high <= RST_MASK;
            irq_mask <= RST_MASK;
        end else if (wr_done) begin
            unique case (acc_idx)
                IDX_SENSE: external_irq_sense_control <= {6'h00, pwdata[1:0]};
                IDX_ENABLE: external_irq_enable <= pwdata[7:0] & IMPL_BITS;
                IDX_MASK_LOW: pin_change_mask_low <= pwdata[7:0];
                IDX_MASK_HIGH: pin_change_mask_high <= pwdata[7:0];
                IDX_IRQ_MASK: irq_mask <= pwdata[7:0] & IMPL_BITS;
                default: ;
            endcase
        end
    end

    assign sense_sel = {external_irq_sense_control[SENSE_HI],
                        external_irq_sense_control[SENSE_LO]};
    assign level_low_mode = (sense_sel == EPI_SENSE_LOW);

    // ------------------------------------------------------------------
    // Sensed pin: synchroniser then edge detection
    // ------------------------------------------------------------------
    // The pin is taken whatever its direction, so software may drive it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_lat <= 1'b1;
            pin_sync <= 1'b1;
            pin_prev <= 1'b1;
        end else begin
            pin_lat <= sense_irq_pin;
            pin_sync <= pin_lat;
            pin_prev <= pin_sync;
        end
    end

    // Edge modes compare two clocked samples; pulses under a period may be lost
    always_comb begin
        sense_event = 1'b0;
        unique case (sense_sel)
            EPI_SENSE_LOW: sense_event = 1'b0;
            EPI_SENSE_ANY: sense_event = pin_sync ^ pin_prev;
            EPI_SENSE_FALL: sense_event = ~pin_sync & pin_prev;
            EPI_SENSE_RISE: sense_event = pin_sync & ~pin_prev;
        endcase
    end

    // ------------------------------------------------------------------
    // Change pins: per pin synchroniser, enable and toggle detection
    // ------------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < PINS; gi++) begin : g_chg
            // Mask bit k of each group register steers pin k of that group
            if (gi < GROUP_W) begin : g_low
                assign pin_enabled[gi] = pin_change_mask_low[gi]
                    & external_irq_enable[BIT_GROUP_LOW];
            end else begin : g_high
                assign pin_enabled[gi] = pin_change_mask_high[gi-GROUP_W]
                    & external_irq_enable[BIT_GROUP_HIGH];
            end

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    chg_lat[gi] <= 1'b0;
                    chg_sync[gi] <= 1'b0;
                    chg_prev[gi] <= 1'b0;
                end else begin
                    chg_lat[gi] <= change_watch_pins[gi];
                    chg_sync[gi] <= chg_lat[gi];
                    chg_prev[gi] <= chg_sync[gi];
                end
            end

            assign pin_toggled[gi] = pin_enabled[gi] & (chg_sync[gi] ^ chg_prev[gi]);
        end
    endgenerate

    // Group set pulses from any enabled toggle in that group
    assign group_low_set = |pin_toggled[GROUP_W-1:0];
    assign group_high_set = |pin_toggled[PINS-1:GROUP_W];

    // ------------------------------------------------------------------
    // Flag register: hardware set beats both kinds of clear
    // ------------------------------------------------------------------
    always_comb begin
        event_set = 8'h00;
        event_set[BIT_PIN] = sense_event;
        event_set[BIT_GROUP_LOW] = group_low_set;
        event_set[BIT_GROUP_HIGH] = group_high_set;
        flag_clear = {handler_entry[2], handler_entry[1], 5'h00, handler_entry[0]};
        if (wr_done && acc_idx == IDX_FLAGS) begin
            flag_clear = flag_clear | (pwdata[7:0] & IMPL_BITS);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            external_irq_flags <= RST_FLAGS;
        end else begin
            external_irq_flags <= (external_irq_flags & ~flag_clear) | event_set;
            if (level_low_mode) begin
                external_irq_flags[BIT_PIN] <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Requests to the processor, one line per vector
    // ------------------------------------------------------------------
    // Low mode requests straight from the level, so it drops when the pin rises
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            req_sense_pin <= 1'b0;
            req_group_low <= 1'b0;
            req_group_high <= 1'b0;
        end else begin
            req_sense_pin <= global_irq_enable & external_irq_enable[BIT_PIN]
                & (level_low_mode ? ~pin_sync : external_irq_flags[BIT_PIN]);
            req_group_low <= global_irq_enable & external_irq_enable[BIT_GROUP_LOW]
                & external_irq_flags[BIT_GROUP_LOW];
            req_group_high <= global_irq_enable & external_irq_enable[BIT_GROUP_HIGH]
                & external_irq_flags[BIT_GROUP_HIGH];
        end
    end

    // ------------------------------------------------------------------
    // Wake request from the synchronised samples
    // ------------------------------------------------------------------
    // Limitation: with a single clock the wake path is registered, not clockless
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wake_request <= 1'b0;
        end else begin
            wake_request <= (|pin_toggled)
                | (level_low_mode & external_irq_enable[BIT_PIN] & ~pin_sync);
        end
    end

    // ------------------------------------------------------------------
    // Sticky event status, cleared by reading it, and the interrupt line
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status <= RST_FLAGS;
        end else if (rd_done && acc_idx == IDX_IRQ_STATUS) begin
            irq_status <= event_set;
        end else begin
            irq_status <= irq_status | event_set;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_status & irq_mask);
        end
    end

endmodule : epi_top

// *** sim/epi_properties.sv ***
// Checker: port properties of the external pin interrupt unit
`timescale 1ns/1ns

module epi_properties
    import epi_pkg::*;
#(
    parameter int PINS = 16, // Change pins
    parameter int GROUP_W = 8 // Pins per group
) (
    input wire logic pclk, // Clock
    input wire logic presetn, // Reset, low
    input wire logic psel, // Select
    input wire logic penable, // Enable
    input wire logic pwrite, // Direction
    input wire logic [epi_pkg::ADDR_W-1:0] paddr, // Address
    input wire logic [31:0] pwdata, // Write data
    input wire logic [31:0] prdata, // Read data
    input wire logic pready, // Ready
    input wire logic pslverr, // Error
    input wire logic sense_irq_pin, // Sensed pin
    input wire logic [PINS-1:0] change_watch_pins, // Change pins
    input wire logic global_irq_enable, // Global enable
    input wire logic [2:0] handler_entry, // Vector taken
    input wire logic req_sense_pin, // Pin request
    input wire logic req_group_low, // Low group request
    input wire logic req_group_high, // High group request
    input wire logic wake_request, // Wake
    input wire logic irq // Event interrupt
);
    // One clock domain, so one clocking and one disable for all
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Bus answer: exactly one access cycle after each setup
    setup_gets_ready_a: assert property ((psel && !penable) |=> pready)
        else $error("no ready after setup");
    ready_one_cycle_a: assert property (pready |=> !pready)
        else $error("ready held past one cycle");
    ready_has_setup_a: assert property (pready |-> $past(psel && !penable) && psel && penable)
        else $error("ready without a setup");
    error_reads_zero_a: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("error outside access or with data");
    read_upper_zero_a: assert property (pready |-> prdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
    // Requests are registered, so the global enable is seen one edge earlier
    pin_req_gated_a: assert property (req_sense_pin |-> $past(global_irq_enable))
        else $error("pin request without global enable");
    low_req_gated_a: assert property (req_group_low |-> $past(global_irq_enable))
        else $error("low group request without global enable");
    high_req_gated_a: assert property (req_group_high |-> $past(global_irq_enable))
        else $error("high group request without global enable");
endmodule : epi_properties

bind epi_top epi_properties #(.PINS(PINS), .GROUP_W(GROUP_W)) u_props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sense_irq_pin(sense_irq_pin), .change_watch_pins(change_watch_pins),
    .global_irq_enable(global_irq_enable), .handler_entry(handler_entry),
    .req_sense_pin(req_sense_pin), .req_group_low(req_group_low),
    .req_group_high(req_group_high), .wake_request(wake_request), .irq(irq));

// *** sim/epi_pin_source.sv ***
// Partner model: board-level drivers of the sensed pin and the change pins
`timescale 1ns/1ns

module epi_pin_source (
    input wire logic pclk, // Bench clock
    input wire logic level_pin, // Wanted sensed-pin level
    input wire logic [15:0] level_change, // Wanted change-pin levels
    output logic sense_irq_pin = 1'b1, // Driven sensed pin
    output logic [15:0] change_watch_pins = 16'h0000 // Driven change pins
);
    // Levels move on an edge and then stay put, so a low level is held long enough
    always @(posedge pclk) begin
        sense_irq_pin <= level_pin;
        change_watch_pins <= level_change;
    end
endmodule : epi_pin_source

// *** sim/external_pin_interrupt_unit_bench.sv ***
// Testbench: self-checking run of the external pin interrupt unit
`timescale 1ns/1ns

module external_pin_interrupt_unit_bench;
    import epi_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err, sense_irq_pin, req_sense_pin, req_group_low, req_group_high;
    logic wake_request, irq, lo, hi;
    logic global_irq_enable = 1'b0;
    logic [2:0] handler_entry = 3'h0;
    logic set_pin = 1'b1;
    logic [15:0] set_change = 16'h0000;
    logic [15:0] change_watch_pins;
    logic [7:0] v, ml, mh;
    logic [IDX_W-1:0] idxs [7] = '{IDX_FLAGS, IDX_ENABLE, IDX_SENSE, IDX_MASK_LOW,
        IDX_MASK_HIGH, IDX_IRQ_STATUS, IDX_IRQ_MASK};
    int n_fail = 0;
    int n_checks = 0;
    int seed = 32'h609F;
    int k;
    logic [1:0] lowbits = 2'b00;
    int n_wake = 0;
    int w0;

    epi_top #(.PINS(16), .GROUP_W(8)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sense_irq_pin(sense_irq_pin),
        .change_watch_pins(change_watch_pins), .global_irq_enable(global_irq_enable),
        .handler_entry(handler_entry), .req_sense_pin(req_sense_pin),
        .req_group_low(req_group_low), .req_group_high(req_group_high),
        .wake_request(wake_request), .irq(irq));
    epi_pin_source u_pins (.pclk(pclk), .level_pin(set_pin), .level_change(set_change),
        .sense_irq_pin(sense_irq_pin), .change_watch_pins(change_watch_pins));

    // ------------------------------------------------------------------
    // Clock, watchdog and shared tasks
    // ------------------------------------------------------------------
    initial begin
        forever #10 pclk = ~pclk;
    end

    // Wake is a one-cycle pulse for toggles, so count pulses rather than sample
    always @(posedge pclk) begin
        if (wake_request === 1'b1) n_wake <= n_wake + 1;
    end

    // Whole run is a few hundred cycles; this span is far beyond it
    initial begin
        #400000;
        n_fail++;
        $display("unexpected run length: expected finish seen timeout");
        print_verdict();
    end

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : print_verdict

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask : check

    // Setup, then access held until ready is sampled high at an edge
    task automatic apb(input logic [IDX_W-1:0] idx, input logic wr, input logic [7:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {idx, lowbits};
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd_chk(input logic [IDX_W-1:0] idx, input logic [31:0] exp, input string w);
        apb(idx, 1'b0, 8'h00);
        check(w, exp, rd);
    endtask : rd_chk

    // Expected edge event of the sensed pin for a sense mode
    function automatic logic pin_event(input logic [1:0] m, input logic was, input logic now);
        case (m)
            EPI_SENSE_ANY: pin_event = was ^ now;
            EPI_SENSE_FALL: pin_event = was & !now;
            EPI_SENSE_RISE: pin_event = !was & now;
            default: pin_event = 1'b0;
        endcase
    endfunction : pin_event

    task automatic pin_step(input logic [1:0] m, input logic lvl);
        logic ev;
        ev = pin_event(m, sense_irq_pin, lvl);
        set_pin <= lvl;
        repeat (7) @(posedge pclk);
        check("pin request", 32'(ev | (m == 2'b00 && !lvl)), 32'(req_sense_pin));
        check("irq", 32'(ev), 32'(irq));
        check("wake", 32'(m == 2'b00 && !lvl), 32'(wake_request));
        rd_chk(IDX_FLAGS, 32'(ev), "pin flag");
        rd_chk(IDX_IRQ_STATUS, 32'(ev), "event status");
        apb(IDX_FLAGS, 1'b1, 8'h01);
        repeat (3) @(posedge pclk);
        check("request after clear", 32'(m == 2'b00 && !lvl), 32'(req_sense_pin));
        check("irq after read", 32'h0, 32'(irq));
    endtask : pin_step

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        foreach (idxs[i]) rd_chk(idxs[i], 32'h0, "reset value");
        apb(10'h3FF, 1'b1, 8'hFF);
        check("unmapped error", 32'h1, 32'(err));
        rd_chk(10'h3FF, 32'h0, "unmapped data");
        lowbits = 2'b10;
        apb(IDX_MASK_LOW, 1'b1, 8'hFF);
        check("misaligned error", 32'h1, 32'(err));
        lowbits = 2'b00;
        rd_chk(IDX_MASK_LOW, 32'h0, "misaligned write");
        for (int i = 0; i < 4; i++) begin
            v = 8'($random(seed));
            apb(IDX_MASK_HIGH, 1'b1, v);
            rd_chk(IDX_MASK_HIGH, 32'(v), "mask high");
            apb(IDX_ENABLE, 1'b1, v);
            rd_chk(IDX_ENABLE, 32'(v & IMPL_BITS), "enable");
        end
        $display("test registers done");
        global_irq_enable <= 1'b1;
        apb(IDX_ENABLE, 1'b1, 8'h01);
        apb(IDX_IRQ_MASK, 1'b1, 8'h01);
        for (int m = 0; m < 4; m++) begin
            apb(IDX_SENSE, 1'b1, 8'(m));
            pin_step(2'(m), 1'b0);
            pin_step(2'(m), 1'b1);
        end
        global_irq_enable <= 1'b0;
        set_pin <= 1'b0;
        repeat (4) @(posedge pclk);
        set_pin <= 1'b1;
        repeat (7) @(posedge pclk);
        check("pin request gated", 32'h0, 32'(req_sense_pin));
        rd_chk(IDX_FLAGS, 32'h1, "pin flag ungated");
        // Level mode must drop a flag left over from an edge mode
        apb(IDX_SENSE, 1'b1, 8'h00);
        rd_chk(IDX_FLAGS, 32'h0, "pin flag in low mode");
        $display("test sensed pin done");
        // Random pin and masks; first pass has both masks clear
        global_irq_enable <= 1'b1;
        apb(IDX_ENABLE, 1'b1, 8'hC0);
        for (int i = 0; i < 12; i++) begin
            ml = (i == 0) ? 8'h00 : 8'($random(seed));
            mh = (i == 0) ? 8'h00 : 8'($random(seed));
            k = (i == 1) ? 15 : (i == 2) ? 8 : int'({$random(seed)} % 16);
            apb(IDX_MASK_LOW, 1'b1, ml);
            apb(IDX_MASK_HIGH, 1'b1, mh);
            w0 = n_wake;
            set_change[k] <= !set_change[k];
            repeat (7) @(posedge pclk);
            lo = (k < 8) && ml[k % 8];
            hi = (k >= 8) && mh[k % 8];
            check("group low request", 32'(lo), 32'(req_group_low));
            check("group high request", 32'(hi), 32'(req_group_high));
            check("wake pulses", 32'(lo | hi), 32'(n_wake - w0));
            rd_chk(IDX_FLAGS, {24'h0, hi, lo, 6'h0}, "group flags");
            handler_entry <= {hi, lo, 1'b0};
            @(posedge pclk);
            handler_entry <= 3'h0;
            repeat (3) @(posedge pclk);
            rd_chk(IDX_FLAGS, 32'h0, "flags after handler");
        end
        $display("test change pins done");
        print_verdict();
    end
endmodule : external_pin_interrupt_unit_bench
